// ### hw/fall_edge_sync.sv
// two-flop synchroniser for a pin, with a falling-edge pulse on the synchronised level
// assumes the pin idles high (recessive bus level)
module fall_edge_sync (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic pinIn,
    output logic fallPulse
);

    logic meta_q;
    logic sync_q;
    logic last_q;

    // meta_q feeds sync_q only; the edge compare looks at later stages
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            last_q <= 1'b1;
        end else begin
            meta_q <= pinIn;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign fallPulse = last_q & ~sync_q;

endmodule : fall_edge_sync

// ### hw/hist_record_ram.sv
// record storage of the history queue: one write port, one combinational read port
// assumes the writer never writes and reads past its own full/empty bookkeeping
module hist_record_ram #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 36
) (
    input wire logic ref_clk,
    input wire logic wrEn,
    input wire logic [$clog2(DEPTH)-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    input wire logic [$clog2(DEPTH)-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData
);

    logic [WIDTH-1:0] mem [DEPTH];

    // no reset on the array: contents only count while the queue says so
    always_ff @(posedge ref_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    assign rdData = mem[rdAddr];

endmodule : hist_record_ram

// ### hw/tx_history_list.sv
// transmit history queue of one channel with its register port and interrupt grouping
// assumes transmit events, request levels and channel mode come from ref_clk logic;
// only the bus receive pin is asynchronous
// How it works
// - one history queue per channel, holding up to eight records
// - record appended only after an error-free transmission, with kind, index, stamp, label
// - each submitted frame chooses whether a record is kept and its label
// - index field gives dedicated buffers 0 to 3 as 00 to 11
// - kind field is 01 for a dedicated buffer, 10 for the shared fifo
// - fifo-sent records report the buffer number linked to the fifo
// - record words read only while the page select is 01
// - writing ff to the pointer control advances to the next record
// - a record is stored within 70 cycles of the transmission
// - entry-lost flag stays set until software writes zero
// - disabling the queue leaves the history request flag set
// - mode bit picks request per record or at six records
// - own enable gates the history request into the transmit interrupt
// - transmit interrupt joins four sources, all shown in a status register
// - overflow raises global error when the module-wide enable is set
// - channel error interrupt joins the eleven error sources
// - wake-up fires on a falling edge of the bus receive line
// - ram protection fires on a corrected or detected ram error
// - entry lost when a record arrives while the queue is full
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
module tx_history_list #(
    parameter int DEPTH = tx_hist_pkg::HIST_DEPTH,
    parameter int TS_W = tx_hist_pkg::TS_W,
    parameter int LABEL_W = tx_hist_pkg::LABEL_W
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    input wire logic txDone,
    input wire logic txOk,
    input wire logic txFromFifo,
    input wire logic [1:0] txBufIndex,
    input wire logic [TS_W-1:0] txTimestamp,
    input wire logic [LABEL_W-1:0] txLabel,
    input wire logic txKeepHist,
    input wire logic [1:0] chanMode,
    input wire logic txCompleteReq,
    input wire logic txAbortReq,
    input wire logic fifoTxCompleteReq,
    input wire logic dlcErrReq,
    input wire logic fifoMsgLostReq,
    input wire logic payloadOvfReq,
    input wire logic [10:0] chanErrSrc,
    input wire logic canRxPin,
    input wire logic eccSingleFixed,
    input wire logic eccDoubleFound,
    output logic txIrq,
    output logic globErrIrq,
    output logic chanErrIrq,
    output logic wakeIrq,
    output logic eccIrq
);

    // ***************************************************************
    // sizes and elaboration check
    // ***************************************************************
    localparam int PW = $clog2(DEPTH);
    localparam int CW = PW + 1;
    localparam int REC_W = LABEL_W + TS_W + 4;

    if (DEPTH < tx_hist_pkg::IRQ_BATCH || (DEPTH & (DEPTH - 1)) != 0) begin : bad_depth
        $error("DEPTH must be a power of two and hold a full batch");
    end
    if (TS_W > 32 || LABEL_W > 32) begin : bad_width
        $error("timestamp and label must fit one word");
    end

    // ***************************************************************
    // state
    // ***************************************************************
    logic [1:0] pageSel_q;
    logic queueOn_q;
    logic irqOn_q;
    logic irqMode_q;
    logic [3:0] gctl_q;
    logic [1:0] fifoLink_q;
    logic [PW-1:0] wrPtr_q;
    logic [PW-1:0] rdPtr_q;
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic lost_q;
    logic histIrq_q;
    logic [3:0] gtis_q;
    tx_hist_pkg::store_state_t state_q;
    logic [REC_W-1:0] rec_q;
    logic [REC_W-1:0] headRec;
    logic [31:0] rdData_q;
    logic [31:0] rdData_d;
    logic txIrq_q;
    logic globErrIrq_q;
    logic chanErrIrq_q;
    logic wakeIrq_q;
    logic eccIrq_q;
    logic wakeFall;

    // ***************************************************************
    // decode
    // ***************************************************************
    logic wrWin, wrQcfg, wrState, wrPtrCtl, wrGctl, wrFifo;
    logic chanLive, empty, full, capture, storeGo, storeEn, lostSet, advance;
    logic histSet, histClr, lostClr;

    assign wrWin = regWr && regAddr == tx_hist_pkg::OFS_WIN_CTRL;
    assign wrQcfg = regWr && regAddr == tx_hist_pkg::OFS_QCFG;
    assign wrState = regWr && regAddr == tx_hist_pkg::OFS_QSTATE;
    assign wrPtrCtl = regWr && regAddr == tx_hist_pkg::OFS_PTR_CTRL;
    assign wrGctl = regWr && regAddr == tx_hist_pkg::OFS_GLOBAL_CONTROL;
    assign wrFifo = regWr && regAddr == tx_hist_pkg::OFS_FIFO_CFG;
    assign chanLive = chanMode == tx_hist_pkg::MODE_OPER || chanMode == tx_hist_pkg::MODE_HALT;
    assign empty = count_q == '0;
    assign full = count_q == CW'(DEPTH);
    // only good frames marked for history are captured
    assign capture = txDone && txOk && txKeepHist && queueOn_q;
    assign storeGo = state_q == tx_hist_pkg::ST_STORE && queueOn_q;
    assign storeEn = storeGo && !full;
    assign lostSet = storeGo && full;
    // advance ignored unless enabled and holding a record
    assign advance = wrPtrCtl && regWrData[7:0] == tx_hist_pkg::PTR_ADVANCE_KEY
        && queueOn_q && !empty;
    assign lostClr = wrState && !regWrData[tx_hist_pkg::ST_LOST_BIT];
    assign histClr = wrState && !regWrData[tx_hist_pkg::ST_IRQ_BIT];

    // ***************************************************************
    // configuration registers
    // ***************************************************************
    // page select and module-wide settings
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            pageSel_q <= tx_hist_pkg::RST_PAGE;
            gctl_q <= tx_hist_pkg::RST_GLOBAL_CONTROL;
            fifoLink_q <= tx_hist_pkg::RST_FIFO_LINK;
        end else begin
            if (wrWin) begin
                pageSel_q <= regWrData[1:0];
            end
            if (wrGctl) begin
                gctl_q <= regWrData[3:0];
            end
            if (wrFifo) begin
                fifoLink_q <= regWrData[1:0];
            end
        end
    end

    // queue config; enable only moves in operation or halt, channel reset drops it
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            queueOn_q <= 1'b0;
            irqOn_q <= 1'b0;
            irqMode_q <= 1'b0;
        end else begin
            if (chanMode == tx_hist_pkg::MODE_RESET) begin
                queueOn_q <= 1'b0;
            end else if (wrQcfg && chanLive) begin
                queueOn_q <= regWrData[tx_hist_pkg::QC_ON_BIT];
            end
            if (wrQcfg) begin
                irqOn_q <= regWrData[tx_hist_pkg::QC_IRQ_ON_BIT];
                irqMode_q <= regWrData[tx_hist_pkg::QC_IRQ_MODE_BIT];
            end
        end
    end

    // ***************************************************************
    // capture and store
    // ***************************************************************
    // record latched one cycle, written the next: well inside the allowed delay
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state_q <= tx_hist_pkg::ST_IDLE;
            rec_q <= '0;
        end else begin
            case (state_q)
                tx_hist_pkg::ST_IDLE: begin
                    if (capture) begin
                        state_q <= tx_hist_pkg::ST_STORE;
                    end
                end
                tx_hist_pkg::ST_STORE: begin
                    if (!capture) begin
                        state_q <= tx_hist_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= tx_hist_pkg::ST_IDLE;
                end
            endcase
            if (capture) begin
                rec_q[1:0] <= txFromFifo ? tx_hist_pkg::KIND_FIFO
                    : tx_hist_pkg::KIND_TXBUF;
                rec_q[3:2] <= txFromFifo ? fifoLink_q : txBufIndex;
                rec_q[4 +: TS_W] <= txTimestamp;
                rec_q[4 + TS_W +: LABEL_W] <= txLabel;
            end
        end
    end

    hist_record_ram #(
        .DEPTH(DEPTH),
        .WIDTH(REC_W)
    ) u_ram (
        .ref_clk(ref_clk),
        .wrEn(storeEn),
        .wrAddr(wrPtr_q),
        .wrData(rec_q),
        .rdAddr(rdPtr_q),
        .rdData(headRec)
    );

    // next occupancy; a full-queue arrival changes nothing
    always_comb begin
        count_d = count_q;
        case ({storeEn, advance})
            2'b10: count_d = count_q + CW'(1);
            2'b01: count_d = count_q - CW'(1);
            default: count_d = count_q;
        endcase
    end

    // pointers; disabling empties the queue so re-enable starts clean
    always_ff @(posedge ref_clk) begin
        if (!rst_b || !queueOn_q) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (storeEn) begin
                wrPtr_q <= wrPtr_q + PW'(1);
            end
            if (advance) begin
                rdPtr_q <= rdPtr_q + PW'(1);
            end
            count_q <= count_d;
        end
    end

    // ***************************************************************
    // sticky flags: set beats a clearing write in the same cycle
    // ***************************************************************
    assign histSet = storeEn && (!irqMode_q || count_d == CW'(tx_hist_pkg::IRQ_BATCH));

    // disable does not touch these; only a zero write clears
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            lost_q <= 1'b0;
            histIrq_q <= 1'b0;
        end else begin
            lost_q <= lostSet || (lost_q && !lostClr);
            histIrq_q <= histSet || (histIrq_q && !histClr);
        end
    end

    // ***************************************************************
    // interrupt grouping
    // ***************************************************************
    fall_edge_sync u_wake (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .pinIn(canRxPin),
        .fallPulse(wakeFall)
    );

    // all outputs registered, one cycle behind their sources
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            gtis_q <= '0;
            txIrq_q <= 1'b0;
            globErrIrq_q <= 1'b0;
            chanErrIrq_q <= 1'b0;
            wakeIrq_q <= 1'b0;
            eccIrq_q <= 1'b0;
        end else begin
            gtis_q <= {histIrq_q && irqOn_q, fifoTxCompleteReq, txAbortReq,
                txCompleteReq};
            txIrq_q <= txCompleteReq || txAbortReq || fifoTxCompleteReq
                || (histIrq_q && irqOn_q);
            globErrIrq_q <= (lost_q && gctl_q[tx_hist_pkg::GC_LOST_IE_BIT])
                || (dlcErrReq && gctl_q[tx_hist_pkg::GC_DLC_IE_BIT])
                || (fifoMsgLostReq && gctl_q[tx_hist_pkg::GC_MSGLOST_IE_BIT])
                || (payloadOvfReq && gctl_q[tx_hist_pkg::GC_PAYLOAD_IE_BIT]);
            chanErrIrq_q <= |chanErrSrc;
            wakeIrq_q <= wakeFall;
            eccIrq_q <= eccSingleFixed || eccDoubleFound;
        end
    end

    // ***************************************************************
    // read port
    // ***************************************************************
    // record words read zero unless the history page is selected
    always_comb begin
        rdData_d = '0;
        case (regAddr)
            tx_hist_pkg::OFS_WIN_CTRL: rdData_d[1:0] = pageSel_q;
            tx_hist_pkg::OFS_QCFG: begin
                rdData_d[tx_hist_pkg::QC_ON_BIT] = queueOn_q;
                rdData_d[tx_hist_pkg::QC_IRQ_ON_BIT] = irqOn_q;
                rdData_d[tx_hist_pkg::QC_IRQ_MODE_BIT] = irqMode_q;
            end
            tx_hist_pkg::OFS_QSTATE: begin
                rdData_d[tx_hist_pkg::ST_EMPTY_BIT] = empty;
                rdData_d[tx_hist_pkg::ST_FULL_BIT] = full;
                rdData_d[tx_hist_pkg::ST_LOST_BIT] = lost_q;
                rdData_d[tx_hist_pkg::ST_IRQ_BIT] = histIrq_q;
                rdData_d[tx_hist_pkg::ST_CNT_LSB +: CW] = count_q;
            end
            tx_hist_pkg::OFS_W0_LOW: begin
                if (pageSel_q == tx_hist_pkg::PAGE_HIST) begin
                    rdData_d[tx_hist_pkg::W0_KIND_LSB +: 2] = headRec[1:0];
                    rdData_d[tx_hist_pkg::W0_INDEX_LSB +: 2] = headRec[3:2];
                end
            end
            tx_hist_pkg::OFS_W1_LOW: begin
                if (pageSel_q == tx_hist_pkg::PAGE_HIST) begin
                    rdData_d[TS_W-1:0] = headRec[4 +: TS_W];
                end
            end
            tx_hist_pkg::OFS_W1_HIGH: begin
                if (pageSel_q == tx_hist_pkg::PAGE_HIST) begin
                    rdData_d[LABEL_W-1:0] = headRec[4 + TS_W +: LABEL_W];
                end
            end
            tx_hist_pkg::OFS_GLOBAL_CONTROL: rdData_d[3:0] = gctl_q;
            tx_hist_pkg::OFS_GTIS: rdData_d[3:0] = gtis_q;
            tx_hist_pkg::OFS_FIFO_CFG: rdData_d[1:0] = fifoLink_q;
            default: rdData_d = '0;
        endcase
    end

    // data stand only in the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rdData_q <= '0;
        end else begin
            rdData_q <= regRd ? rdData_d : '0;
        end
    end

    assign regRdData = rdData_q;
    assign txIrq = txIrq_q;
    assign globErrIrq = globErrIrq_q;
    assign chanErrIrq = chanErrIrq_q;
    assign wakeIrq = wakeIrq_q;
    assign eccIrq = eccIrq_q;

    // ***************************************************************
    // assertions
    // ***************************************************************
    localparam int StoreMax = tx_hist_pkg::STORE_MAX_CYC;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    count_bound_a: assert property (count_q <= CW'(DEPTH))
        else $error("queue holds more than its depth");
    store_delay_a: assert property ((capture && !full) |-> ##[1:StoreMax] storeEn)
        else $error("record not stored in time");
    good_only_a: assert property ((txDone && !txOk) |=> state_q == tx_hist_pkg::ST_IDLE)
        else $error("failed frame started a store");
    kind_buf_a: assert property ((capture && !txFromFifo) |=>
        rec_q[1:0] == tx_hist_pkg::KIND_TXBUF && rec_q[3:2] == $past(txBufIndex))
        else $error("dedicated buffer record wrong");
    kind_fifo_a: assert property ((capture && txFromFifo) |=>
        rec_q[1:0] == tx_hist_pkg::KIND_FIFO && rec_q[3:2] == $past(fifoLink_q))
        else $error("fifo record wrong");
    page_gate_a: assert property ((regRd && regAddr == tx_hist_pkg::OFS_W1_HIGH
        && pageSel_q != tx_hist_pkg::PAGE_HIST) |=> regRdData == '0)
        else $error("record word visible off page");
    advance_step_a: assert property ((advance && !storeEn) |=>
        count_q == $past(count_q) - CW'(1) && rdPtr_q == $past(rdPtr_q) + PW'(1))
        else $error("pointer advance failed");
    lost_set_a: assert property (lostSet |=> lost_q && count_q == $past(count_q))
        else $error("overflow not flagged or queue touched");
    lost_hold_a: assert property ((lost_q && !lostClr) |=> lost_q)
        else $error("entry lost flag dropped by itself");
    irq_hold_a: assert property ((histIrq_q && !histClr) |=> histIrq_q)
        else $error("history request dropped without a write");
    batch_irq_a: assert property ((irqMode_q && storeEn && !histIrq_q
        && count_q < CW'(tx_hist_pkg::IRQ_BATCH - 1) && !advance) |=> !histIrq_q || histClr)
        else $error("batch request before six records");
    tx_irq_a: assert property ((histIrq_q && irqOn_q) |=> txIrq && gtis_q[3])
        else $error("history request not joined");
    glob_err_a: assert property ((lost_q && gctl_q[tx_hist_pkg::GC_LOST_IE_BIT])
        |=> globErrIrq)
        else $error("entry lost missed global error");

    store_seen_c: cover property (storeEn ##[1:20] advance);
    lost_seen_c: cover property (lostSet);
    batch_seen_c: cover property (irqMode_q && histSet);
    wake_seen_c: cover property (wakeIrq);

endmodule : tx_history_list

// ### include/tx_hist_pkg.sv
// shared constants of the transmit history list block: offsets, fields, counts, states
// assumes one clock (ref_clk, 200 MHz) and a plain register port of byte addresses
package tx_hist_pkg;

    // ***************************************************************
    // sizes and timing
    // ***************************************************************
    localparam int HIST_DEPTH = 8;       // records per channel
    localparam int IRQ_BATCH = 6;        // records that raise the batch request
    localparam int STORE_MAX_CYC = 70;   // longest store delay, in fCLK cycles
    localparam int TS_W = 16;            // timestamp width
    localparam int LABEL_W = 16;         // label width

    // ***************************************************************
    // register offsets (byte addresses, one word each)
    // ***************************************************************
    localparam logic [7:0] OFS_WIN_CTRL = 8'h00;   // ram_window_ctrl
    localparam logic [7:0] OFS_QCFG = 8'h04;       // hist_queue_config
    localparam logic [7:0] OFS_QSTATE = 8'h08;     // hist_queue_state
    localparam logic [7:0] OFS_PTR_CTRL = 8'h0c;   // hist_ptr_ctrl
    localparam logic [7:0] OFS_W0_LOW = 8'h10;     // history_word0_low
    localparam logic [7:0] OFS_W0_HIGH = 8'h14;    // history_word0_high
    localparam logic [7:0] OFS_W1_LOW = 8'h18;     // history_word1_low
    localparam logic [7:0] OFS_W1_HIGH = 8'h1c;    // history_word1_high
    localparam logic [7:0] OFS_GLOBAL_CONTROL = 8'h20;      // global_control
    localparam logic [7:0] OFS_GTIS = 8'h24;       // global_tx_irq_state
    localparam logic [7:0] OFS_FIFO_CFG = 8'h28;   // fifo_config_high

    // ***************************************************************
    // field positions
    // ***************************************************************
    localparam int QC_ON_BIT = 0;
    localparam int QC_IRQ_ON_BIT = 8;
    localparam int QC_IRQ_MODE_BIT = 9;
    localparam int ST_EMPTY_BIT = 0;
    localparam int ST_FULL_BIT = 1;
    localparam int ST_LOST_BIT = 2;
    localparam int ST_IRQ_BIT = 3;
    localparam int ST_CNT_LSB = 8;
    localparam int W0_KIND_LSB = 0;
    localparam int W0_INDEX_LSB = 4;
    localparam int GC_LOST_IE_BIT = 0;
    localparam int GC_DLC_IE_BIT = 1;
    localparam int GC_MSGLOST_IE_BIT = 2;
    localparam int GC_PAYLOAD_IE_BIT = 3;

    // ***************************************************************
    // encodings and reset values
    // ***************************************************************
    localparam logic [1:0] PAGE_HIST = 2'h1;
    localparam logic [1:0] KIND_TXBUF = 2'h1;
    localparam logic [1:0] KIND_FIFO = 2'h2;
    localparam logic [7:0] PTR_ADVANCE_KEY = 8'hff;
    localparam logic [1:0] MODE_OPER = 2'h0;
    localparam logic [1:0] MODE_RESET = 2'h1;
    localparam logic [1:0] MODE_HALT = 2'h2;
    localparam logic [1:0] RST_PAGE = 2'h0;
    localparam logic [3:0] RST_GLOBAL_CONTROL = 4'h0;
    localparam logic [1:0] RST_FIFO_LINK = 2'h0;

    typedef enum logic {ST_IDLE, ST_STORE} store_state_t;

endpackage : tx_hist_pkg

// ### sim/tb.sv
// bench of the transmit history list: records, paging, overflow, flags, irq grouping
// assumes the design files compiled before it; one 200 MHz clock, sync active-low reset
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ***************************************************************
    // stimulus signals, all given a value at time zero
    // ***************************************************************
    logic ref_clk = 1'h0, rst_b = 1'h0, regWr = 1'h0, regRd = 1'h0, txDone = 1'h0;
    logic txOk = 1'h0, txFromFifo = 1'h0, txKeepHist = 1'h0, canRxPin = 1'h1;
    logic txCompleteReq = 1'h0, txAbortReq = 1'h0, fifoTxCompleteReq = 1'h0, dlcErrReq = 1'h0;
    logic fifoMsgLostReq = 1'h0, payloadOvfReq = 1'h0, eccSingleFixed = 1'h0;
    logic eccDoubleFound = 1'h0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0, rdVal, regRdData;
    logic [1:0] txBufIndex = 2'h0, chanMode = 2'h0;
    logic [15:0] txTimestamp = 16'h0, txLabel = 16'h0;
    logic [10:0] chanErrSrc = 11'h0;
    logic txIrq, globErrIrq, chanErrIrq, wakeIrq, eccIrq, seen;
    int n_fail = 0, comparisons = 0;
    // rows: fifo, buffer index, stamp, label, expected word0 (fifo link set to 3)
    logic [42:0] rows [4] = '{{1'h0, 2'h0, 16'h1234, 16'habcd, 8'h01},
        {1'h0, 2'h3, 16'h0002, 16'h5a5a, 8'h31}, {1'h1, 2'h1, 16'hfffe, 16'h0001, 8'h32},
        {1'h0, 2'h2, 16'h8000, 16'h7fff, 8'h21}};

    tx_history_list i_dut (.*);

    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    // ***************************************************************
    // bus and event tasks; strobes last exactly one cycle
    // ***************************************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'h1;
        @(posedge ref_clk);
        regWr <= 1'h0;
        // one idle edge so a following write never re-raises the strobe in the same step
        @(posedge ref_clk);
    endtask : wr
    // read data stands only in the cycle after the strobe, so sample just then
    task automatic rd(input logic [7:0] a);
        regAddr <= a;
        regRd <= 1'h1;
        @(posedge ref_clk);
        regRd <= 1'h0;
        #1 rdVal = regRdData;
        @(posedge ref_clk);
    endtask : rd
    // one finished frame, then room for the two-cycle store and the irq register
    task automatic tx(input logic f, input logic [1:0] b, input logic [15:0] s, l, input logic k);
        {txFromFifo, txBufIndex, txTimestamp, txLabel, txKeepHist} <= {f, b, s, l, k};
        txOk <= 1'h1;
        txDone <= 1'h1;
        @(posedge ref_clk);
        txDone <= 1'h0;
        // ends on an edge; outputs read next are those of the cycle just ended
        repeat (3) @(posedge ref_clk);
    endtask : tx
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    // ***************************************************************
    // main sequence
    // ***************************************************************
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'h1;
        @(posedge ref_clk);
        rd(8'h08);
        chk(rdVal, 32'h1);
        wr(8'h28, 32'h3);
        wr(8'h04, 32'h1);
        wr(8'h00, 32'h1);
        for (int i = 0; i < 4; i++) begin
            tx(rows[i][42], rows[i][41:40], rows[i][39:24], rows[i][23:8], 1'h1);
            rd(8'h10);
            chk(rdVal, {24'h0, rows[i][7:0]});
            rd(8'h18);
            chk(rdVal, {16'h0, rows[i][39:24]});
            rd(8'h1c);
            chk(rdVal, {16'h0, rows[i][23:8]});
            wr(8'h0c, 32'hff);
        end
        tx(1'h0, 2'h1, 16'h1, 16'h1, 1'h0); // frame asks for no record
        rd(8'h08);
        chk(rdVal, 32'h9);
        wr(8'h08, 32'h0);
        // batch request at six, then overflow on the ninth record
        wr(8'h20, 32'h1);
        wr(8'h04, 32'h301);
        for (int i = 0; i < 9; i++) begin
            tx(1'h0, 2'h0, 16'h0, 16'h00a0 + 16'(i), 1'h1);
            if (i < 6) chk({31'h0, txIrq}, {31'h0, i == 5});
            chk({31'h0, globErrIrq}, {31'h0, i == 8});
        end
        rd(8'h08);
        chk(rdVal, 32'h80e);
        rd(8'h1c);
        chk(rdVal, 32'ha0);
        wr(8'h00, 32'h0);
        rd(8'h10);
        chk(rdVal, 32'h0);
        // disabling keeps both sticky flags; only a zero write clears them
        wr(8'h04, 32'h300);
        rd(8'h08);
        chk(rdVal, 32'hd);
        chk({31'h0, txIrq}, 32'h1);
        wr(8'h04, 32'h0);
        rd(8'h08);
        chk({31'h0, txIrq}, 32'h0);
        wr(8'h08, 32'h0);
        rd(8'h08);
        chk(rdVal, 32'h1);
        // remaining interrupt groups; a falling receive pin gives a wake pulse
        {txCompleteReq, txAbortReq, eccDoubleFound, canRxPin} <= 4'he;
        chanErrSrc <= 11'h400;
        seen = 1'h0;
        repeat (6) @(posedge ref_clk) seen |= wakeIrq;
        chk({29'h0, txIrq, chanErrIrq, eccIrq}, 32'h7);
        chk({31'h0, seen}, 32'h1);
        rd(8'h24);
        chk(rdVal, 32'h3);
        give_verdict();
    end
    // watchdog: the run needs well under one microsecond
    initial begin
        #20us;
        n_fail++;
        give_verdict();
    end
endmodule : tb
